// *** sim/oks_host_model.sv ***
// Purpose: Host side model that drives the SPI selects and clock and shares interrupt pin b.
// Assumes: The SPI clock has a 48 ns period and stands still outside frames.
// Notes: The host drives pin b only while the device leaves it undriven.
`timescale 1ns/1ps
`default_nettype none
module oks_host_model (
    // SPI pins.
    output logic spi_sck,
    output logic config_port_select_n,
    output logic fifo_port_select_n,
    // Shared interrupt pin b.
    input wire logic hold_low,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level
);
    // The device wins the pin while it drives it; otherwise the host holds it low or high.
    assign pin_level = pin_oe ? pin_out : !hold_low;

    // Idle: both selects high and the clock parked low.
    initial begin
        spi_sck = 1'b0;
        config_port_select_n = 1'b1;
        fifo_port_select_n = 1'b1;
    end

    // One frame of n clocks; the selects keep their frame levels when it returns so the bench can look.
    task automatic frame(input logic cfg_n, input logic fifo_n, input int n);
        config_port_select_n = cfg_n;
        fifo_port_select_n = fifo_n;
        repeat (n) begin
            #24 spi_sck = 1'b1;
            #24 spi_sck = 1'b0;
        end
    endtask

    // Ends the frame by releasing both selects.
    task automatic release_sel();
        config_port_select_n = 1'b1;
        fifo_port_select_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// *** sim/test_ook_slicer_bitsync_mode_ctrl.sv ***
// Purpose: Self-checking bench for the OOK slicer, bit synchronizer and mode control.
// Assumes: Inputs change 1 ns after the clock edge; strength is in half-dB steps.
// Notes: Bit periods use small dividers so the whole run stays short.
`timescale 1ns/1ps
`default_nettype none
module test_ook_slicer_bitsync_mode_ctrl;
    import oks_pkg::*;
    // Bench-driven inputs.
    logic clk, arst_n, bit_sync_disable, clock_output_enable, rssi_strobe, hold_low;
    logic irq_a_src, irq_b_src, miso_src;
    logic [2:0] chip_operating_state, ook_threshold_decay_step, ook_threshold_decay_rate;
    logic [1:0] data_path_mode, ook_threshold_style, ook_average_cutoff_sel;
    logic [7:0] ook_floor_level, bit_rate_divider, rssi_sample;
    // Host pins and design outputs.
    wire spi_sck, config_port_select_n, fifo_port_select_n, interrupt_line_b_in;
    logic interrupt_line_a_out, interrupt_line_a_oe, interrupt_line_b_out, interrupt_line_b_oe;
    logic data_out, data_oe, fifo_bit, fifo_bit_strobe, clkout_out, clkout_oe, slicer_bit;
    logic rssi_enable, demod_enable, rx_digital_enable, synth_enable, tx_enable;
    logic bit_sync_active, miso_out, miso_oe, spi_config_active, spi_fifo_active;
    int n_fail = 0;
    int num_checks = 0;

    oks_slicer_sync oks_slicer_sync_inst (.clk, .arst_n, .spi_sck, .chip_operating_state,
        .data_path_mode, .ook_threshold_style, .ook_threshold_decay_step,
        .ook_threshold_decay_rate, .ook_floor_level, .ook_average_cutoff_sel,
        .bit_sync_disable, .bit_rate_divider, .clock_output_enable, .rssi_sample,
        .rssi_strobe, .irq_a_src, .irq_b_src, .interrupt_line_a_out, .interrupt_line_a_oe,
        .interrupt_line_b_in, .interrupt_line_b_out, .interrupt_line_b_oe, .data_out,
        .data_oe, .fifo_bit, .fifo_bit_strobe, .clkout_out, .clkout_oe, .rssi_enable,
        .demod_enable, .rx_digital_enable, .synth_enable, .tx_enable, .bit_sync_active,
        .slicer_bit, .config_port_select_n, .fifo_port_select_n, .miso_src, .miso_out,
        .miso_oe, .spi_config_active, .spi_fifo_active);

    oks_host_model oks_host_model_inst (.spi_sck, .config_port_select_n, .fifo_port_select_n,
        .hold_low, .pin_out(interrupt_line_b_out), .pin_oe(interrupt_line_b_oe),
        .pin_level(interrupt_line_b_in));

    // Crystal clock, 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Watchdog well beyond the roughly 80 us that the tests take.
    initial begin
        #500000;
        n_fail++;
        tally_and_finish();
    end

    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One strength sample; returns once the slicer and data pin have settled.
    task automatic strb(input logic [7:0] v);
        rssi_sample = v;
        rssi_strobe = 1'b1;
        step(1);
        rssi_strobe = 1'b0;
        step(2);
    endtask

    // Cycles until the next rising edge of the recovered clock, bounded.
    task automatic wait_rise(output int n);
        logic p;
        n = 0;
        do begin
            p = interrupt_line_b_out;
            step(1);
            n++;
        end while (!(interrupt_line_b_out === 1'b1 && p === 1'b0) && n < 400);
    endtask

    task automatic t_modes();
        logic p;
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 6; s++) begin
                chip_operating_state = 3'(s);
                data_path_mode = 2'(m);
                step(3);
                chk("rx_blocks", 9'({3{s == 3}}), 9'({rssi_enable, demod_enable, rx_digital_enable}));
                chk("synth", 9'(s >= 2 && s <= 4), 9'(synth_enable));
                chk("tx", 9'(s == 4), 9'(tx_enable));
                chk("irq_oe", 9'({2{s == 3 || s == 4 || ((s == 1 || s == 2) && m != 0)}}),
                    9'({interrupt_line_a_oe, interrupt_line_b_oe}));
                chk("clkout_oe", 9'(s >= 1 && s <= 4), 9'(clkout_oe));
                chk("data_oe", 9'(s == 3), 9'(data_oe));
            end
        end
        chip_operating_state = 3'h1;
        clock_output_enable = 1'b1;
        step(3);
        p = clkout_out;
        step(1);
        chk("clkout_run", 9'(!p), 9'(clkout_out));
        clock_output_enable = 1'b0;
        step(3);
        chk("clkout_off", 9'h000, 9'(clkout_out));
    endtask

    task automatic t_slice();
        chip_operating_state = 3'h3;
        data_path_mode = OKS_DM_CONT;
        ook_threshold_style = OKS_FIXED;
        ook_floor_level = 8'h40;
        strb(8'hc0);
        strb(8'h41);
        chk("fixed_hi", 9'h001, 9'(slicer_bit));
        chk("raw_data", 9'h001, 9'(data_out));
        strb(8'h40);
        chk("fixed_lo", 9'h000, 9'(slicer_bit));
        ook_threshold_style = OKS_PEAK;
        ook_floor_level = 8'h00;
        ook_threshold_decay_step = 3'h7;
        // Let the peak left over from the fixed-style samples decay first.
        strb(8'h00);
        step(500);
        strb(8'h80);
        strb(8'h75);
        chk("peak_hi", 9'h001, 9'(slicer_bit));
        strb(8'h74);
        chk("peak_lo", 9'h000, 9'(slicer_bit));
        step(70);
        strb(8'h69);
        chk("slow_decay", 9'h001, 9'(slicer_bit));
        ook_floor_level = 8'h60;
        strb(8'h00);
        step(1000);
        strb(8'h60);
        chk("floor_lo", 9'h000, 9'(slicer_bit));
        strb(8'h61);
        chk("floor_hi", 9'h001, 9'(slicer_bit));
        ook_floor_level = 8'h00;
        ook_threshold_decay_rate = 3'h7;
        ook_threshold_decay_step = 3'h0;
        strb(8'h80);
        strb(8'h00);
        step(33);
        strb(8'h66);
        chk("fast_upper", 9'h000, 9'(slicer_bit));
        strb(8'h6f);
        chk("fast_lower", 9'h001, 9'(slicer_bit));
        ook_threshold_style = OKS_AVERAGE;
        repeat (400) strb(8'h50);
        strb(8'h51);
        chk("avg_hi", 9'h001, 9'(slicer_bit));
        strb(8'h4e);
        chk("avg_lo", 9'h000, 9'(slicer_bit));
        ook_average_cutoff_sel = 2'h3;
        repeat (400) strb(8'h50);
        repeat (20) strb(8'ha0);
        strb(8'h5a);
        chk("avg_slow", 9'h001, 9'(slicer_bit));
    endtask

    task automatic t_sync();
        int n;
        ook_threshold_style = OKS_FIXED;
        ook_floor_level = 8'h40;
        bit_sync_disable = 1'b0;
        bit_rate_divider = 8'h01;
        step(3);
        chk("sync_on", 9'h001, 9'(bit_sync_active));
        for (int i = 0; i < 24; i++) begin
            strb(i[0] ? 8'hff : 8'h00);
            step(125);
        end
        strb(8'h00);
        wait_rise(n);
        chk("clk_centre", 9'h001, 9'(n >= 60 && n <= 70));
        repeat (3) begin
            wait_rise(n);
            chk("bit_period", 9'h080, 9'(n));
            chk("sync_data", 9'h000, 9'(data_out));
        end
        data_path_mode = OKS_DM_BUF;
        bit_sync_disable = 1'b1;
        step(3);
        chk("forced_sync", 9'h001, 9'(bit_sync_active));
        n = 0;
        repeat (256) begin
            step(1);
            n += int'(fifo_bit_strobe === 1'b1);
            if (fifo_bit_strobe === 1'b1) begin
                chk("fifo_data", 9'h000, 9'(fifo_bit));
            end
        end
        chk("fifo_bits", 9'h002, 9'(n));
        chk("pin_quiet", 9'h000, 9'(data_out));
        data_path_mode = OKS_DM_CONT;
        step(3);
        chk("sync_off", 9'h000, 9'(bit_sync_active));
        strb(8'hff);
        chk("bypass_data", 9'h001, 9'(data_out));
        bit_sync_disable = 1'b0;
        for (int h = 1; h >= 0; h--) begin
            chip_operating_state = 3'h1;
            hold_low = h[0];
            step(5);
            chip_operating_state = 3'h3;
            step(3);
            chk("host_hold", 9'(h == 0), 9'(bit_sync_active));
        end
    endtask

    task automatic t_spi();
        miso_src = 1'b1;
        oks_host_model_inst.frame(1'b0, 1'b0, 4);
        chk("both_sel", 9'h004, 9'({spi_config_active, spi_fifo_active, 1'b0}));
        chk("miso_on", 9'h003, 9'({miso_oe, miso_out}));
        oks_host_model_inst.release_sel();
        #30;
        chk("miso_off", 9'h000, 9'(miso_oe));
        oks_host_model_inst.frame(1'b1, 1'b0, 4);
        chk("fifo_sel", 9'h003, 9'({spi_config_active, spi_fifo_active, miso_oe}));
        oks_host_model_inst.release_sel();
        #30;
        chk("idle_sel", 9'h000, 9'({spi_config_active, spi_fifo_active, miso_oe}));
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence: every input set at time zero, reset for 8 cycles, then the tests.
    initial begin
        arst_n = 1'b0;
        chip_operating_state = 3'h0;
        data_path_mode = OKS_DM_CONT;
        ook_threshold_style = OKS_PEAK;
        ook_threshold_decay_step = 3'h0;
        ook_threshold_decay_rate = 3'h0;
        ook_floor_level = 8'h00;
        ook_average_cutoff_sel = 2'h0;
        bit_sync_disable = 1'b1;
        bit_rate_divider = 8'h00;
        clock_output_enable = 1'b0;
        rssi_sample = 8'h00;
        rssi_strobe = 1'b0;
        irq_a_src = 1'b0;
        irq_b_src = 1'b0;
        miso_src = 1'b0;
        hold_low = 1'b0;
        step(8);
        arst_n = 1'b1;
        step(1);
        t_modes();
        t_slice();
        t_sync();
        t_spi();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** src/oks_pkg.sv ***
// Purpose: Shared constants and types for the OOK slicer and bit sync block.
// Assumes: Signal strength comes in half-dB steps; the clock is the crystal.
// Notes: Step and cutoff tables are small functions kept here.
package oks_pkg;

    // Operating states of the chip.
    typedef enum logic [2:0] {
        OKS_SLEEP = 3'h0,
        OKS_STANDBY = 3'h1,
        OKS_SYNTH = 3'h2,
        OKS_RX = 3'h3,
        OKS_TX = 3'h4
    } oks_chip_t;

    // Threshold styles of the slicer.
    typedef enum logic [1:0] {
        OKS_PEAK = 2'h0,
        OKS_FIXED = 2'h1,
        OKS_AVERAGE = 2'h2
    } oks_style_t;

    // Data path modes; any code with the top bit set is packet mode.
    localparam logic [1:0] OKS_DM_CONT = 2'h0;
    localparam logic [1:0] OKS_DM_BUF = 2'h1;

    // Bit period is 64 crystal cycles per divider step.
    localparam int OKS_BR_SHIFT = 6;
    // Peak threshold sits 6 dB (12 half-dB) below the peak.
    localparam logic [8:0] OKS_PEAK_DROP = 9'h00c;
    // Fraction bits of the averager and its update ticks per bit (2^3).
    localparam int OKS_AVG_FRAC = 8;
    localparam int OKS_AVG_TICK_SHIFT = 3;

    // Decay step in half-dB units.
    function automatic logic [8:0] oks_step_hdb(input logic [2:0] code);
        logic [8:0] v;
        v = 9'h001;
        case (code)
            3'h0: v = 9'h001;
            3'h1: v = 9'h002;
            3'h2: v = 9'h003;
            3'h3: v = 9'h004;
            3'h4: v = 9'h006;
            3'h5: v = 9'h008;
            3'h6: v = 9'h00a;
            default: v = 9'h00c;
        endcase
        return v;
    endfunction

    // Averager shift: time constant 4 bits at code 0, 16 bits at code 3.
    function automatic logic [2:0] oks_avg_shift(input logic [1:0] code);
        logic [2:0] v;
        v = 3'h5;
        case (code)
            2'h0: v = 3'h5;
            2'h1: v = 3'h6;
            2'h2: v = 3'h6;
            default: v = 3'h7;
        endcase
        return v;
    endfunction

endpackage

// *** src/oks_slicer_sync.sv ***
// Purpose: OOK threshold slicer, bit synchronizer and chip-mode pin control.
// Assumes: clk is the crystal reference; spi_sck clocks the SPI select logic.
// Notes: Register and FIFO transfers live outside; only pin steering is here.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Decay rate code: slower or faster than bit.
// - Decay step code selects 0.5 to 6 dB.
// - Styles: peak, fixed or averaged threshold.
// - Fixed style compares only against floor level.
// - Averaged style low-pass filters strength samples.
// - Disable bit or host-low pin bypasses sync.
// - Continuous mode drives recovered clock on pin.
// - Buffered or packet mode forces sync on in receive.
// - Bit period is 64 times divider plus one.
// - Clock rise centred in bit, retracked on edges.
// - Matched rates hold lock through long runs.
// - Continuous mode puts bits on data pin.
// - Buffered and packet modes feed FIFO instead.
// - Three-bit state code selects operating state.
// - Receive blocks enabled only in receive state.
// - Clock output runs from standby when enabled.
// - Config select wins when both selects low.
// - SPI output driven only while selected.
// - Interrupt pins tri-state per state and mode.
// - Peak threshold is peak minus 6 dB, decaying.
// - Decaying threshold stops at floor level.
// - Two-bit data mode field decode.
module oks_slicer_sync
    import oks_pkg::*;
(
    // Clocks and reset.
    input wire logic clk,
    input wire logic arst_n,
    input wire logic spi_sck,
    // Configuration.
    input wire logic [2:0] chip_operating_state,
    input wire logic [1:0] data_path_mode,
    input wire logic [1:0] ook_threshold_style,
    input wire logic [2:0] ook_threshold_decay_step,
    input wire logic [2:0] ook_threshold_decay_rate,
    input wire logic [7:0] ook_floor_level,
    input wire logic [1:0] ook_average_cutoff_sel,
    input wire logic bit_sync_disable,
    input wire logic [7:0] bit_rate_divider,
    input wire logic clock_output_enable,
    // Signal strength samples.
    input wire logic [7:0] rssi_sample,
    input wire logic rssi_strobe,
    // Interrupt sources and pins.
    input wire logic irq_a_src,
    input wire logic irq_b_src,
    output logic interrupt_line_a_out,
    output logic interrupt_line_a_oe,
    input wire logic interrupt_line_b_in,
    output logic interrupt_line_b_out,
    output logic interrupt_line_b_oe,
    // Data pin and FIFO side.
    output logic data_out,
    output logic data_oe,
    output logic fifo_bit,
    output logic fifo_bit_strobe,
    // Clock output pin.
    output logic clkout_out,
    output logic clkout_oe,
    // Block enables and status.
    output logic rssi_enable,
    output logic demod_enable,
    output logic rx_digital_enable,
    output logic synth_enable,
    output logic tx_enable,
    output logic bit_sync_active,
    output logic slicer_bit,
    // SPI pins.
    input wire logic config_port_select_n,
    input wire logic fifo_port_select_n,
    input wire logic miso_src,
    output logic miso_out,
    output logic miso_oe,
    output logic spi_config_active,
    output logic spi_fifo_active
);

    typedef struct packed {
        logic irq_b_m;
        logic irq_b_s;
        logic host_hold;
        logic [8:0] peak;
        logic [7:0] thr;
        logic [15:0] avg;
        logic [17:0] decay_cnt;
        logic [14:0] avg_cnt;
        logic [14:0] ph;
        logic slice;
        logic prev_bit;
        logic bs_on;
        logic bs_clk;
        logic bs_bit;
        logic data_out;
        logic data_oe;
        logic irq_a_out;
        logic irq_b_out;
        logic irq_oe;
        logic fifo_bit;
        logic fifo_stb;
        logic clkout;
        logic clkout_oe;
        logic rx_en;
        logic synth_en;
        logic tx_en;
        logic miso_src;
    } oks_state_t;

    oks_state_t s_r;
    oks_state_t s_nxt;
    oks_chip_t chip;
    oks_style_t style;
    logic cont;
    logic [14:0] per;
    logic [14:0] half;
    logic [17:0] interval;

    // Mode decode shared by the process and the checks.
    assign chip = oks_chip_t'(chip_operating_state);
    assign style = oks_style_t'(ook_threshold_style);
    assign cont = (data_path_mode == OKS_DM_CONT);
    // Bit period in crystal cycles.
    assign per = 15'((16'(bit_rate_divider) + 16'h0001) << OKS_BR_SHIFT);
    assign half = per >> 1;
    // Faster codes divide the bit period, slower ones multiply it.
    assign interval = ook_threshold_decay_rate[2]
        ? (18'(per) >> ({1'b0, ook_threshold_decay_rate[1:0]} + 3'h1)) // Three bits, so 16x fits.
        : (18'(per) << ook_threshold_decay_rate[1:0]);

    // Next-state logic for the whole crystal domain.
    always_comb begin
        logic [8:0] flr;
        logic [8:0] step;
        logic [8:0] pk_thr;
        logic decay_tick;
        logic avg_tick;
        logic signed [16:0] diff;
        logic [14:0] ph_n;
        logic rx;
        logic en_pins;
        flr = {1'b0, ook_floor_level};
        step = oks_step_hdb(ook_threshold_decay_step);
        pk_thr = (s_r.peak > flr + OKS_PEAK_DROP) ? s_r.peak - OKS_PEAK_DROP : flr;
        decay_tick = (s_r.decay_cnt >= interval - 18'h00001);
        avg_tick = (s_r.avg_cnt >= (per >> OKS_AVG_TICK_SHIFT) - 15'h0001);
        diff = 17'sh00000;
        ph_n = 15'h0000;
        rx = (chip == OKS_RX);
        en_pins = 1'b0;
        s_nxt = s_r;
        // Host level on the clock pin passes two flops first.
        s_nxt.irq_b_m = interrupt_line_b_in;
        s_nxt.irq_b_s = s_r.irq_b_m;
        // Only trust the host level while we leave the pin undriven.
        if (!s_r.irq_oe) begin
            s_nxt.host_hold = ~s_r.irq_b_s;
        end
        s_nxt.miso_src = miso_src;

        // Decay timer.
        s_nxt.decay_cnt = decay_tick ? 18'h00000 : s_r.decay_cnt + 18'h00001;
        // Peak tracker: a new higher sample beats a decay in the same cycle.
        if (rssi_strobe && {1'b0, rssi_sample} > s_r.peak) begin
            s_nxt.peak = {1'b0, rssi_sample};
        end else if (decay_tick && !s_r.slice) begin
            if (s_r.peak > flr + OKS_PEAK_DROP + step) begin
                s_nxt.peak = s_r.peak - step;
            end else begin
                s_nxt.peak = flr + OKS_PEAK_DROP;
            end
        end

        // Averager runs eight times per bit.
        s_nxt.avg_cnt = avg_tick ? 15'h0000 : s_r.avg_cnt + 15'h0001;
        if (avg_tick) begin
            diff = $signed({1'b0, rssi_sample, 8'h00}) - $signed({1'b0, s_r.avg});
            s_nxt.avg = 16'($signed({1'b0, s_r.avg})
                + (diff >>> oks_avg_shift(ook_average_cutoff_sel)));
        end

        // Active threshold; the unused code falls back to peak style.
        unique case (style)
            OKS_FIXED: s_nxt.thr = ook_floor_level;
            OKS_AVERAGE: s_nxt.thr = s_r.avg[OKS_AVG_FRAC +: 8];
            OKS_PEAK: s_nxt.thr = pk_thr[7:0];
            default: s_nxt.thr = pk_thr[7:0];
        endcase
        if (rssi_strobe) begin
            s_nxt.slice = (rssi_sample > s_r.thr);
        end

        // Sync is forced on in receive state outside continuous mode.
        s_nxt.bs_on = rx && (!cont || !(bit_sync_disable || s_r.host_hold));
        // Phase counter: restart on each data edge, else free-run.
        s_nxt.prev_bit = s_r.slice;
        if (!s_r.bs_on || s_r.slice != s_r.prev_bit || s_r.ph >= per - 15'h0001) begin
            ph_n = 15'h0000;
        end else begin
            ph_n = s_r.ph + 15'h0001;
        end
        s_nxt.ph = ph_n;
        s_nxt.bs_clk = s_r.bs_on && (ph_n >= half);
        s_nxt.fifo_stb = 1'b0;
        if (s_r.bs_on && ph_n == half) begin
            s_nxt.bs_bit = s_r.slice;
            s_nxt.fifo_stb = !cont;
            // Bit and strobe leave together so the FIFO never takes the previous bit.
            s_nxt.fifo_bit = s_r.slice;
        end

        // Data pin drives only in receive, carrying bits only in continuous.
        s_nxt.data_oe = rx;
        s_nxt.data_out = cont && (s_r.bs_on ? s_r.bs_bit : s_r.slice);

        // Pin direction and block enables per state.
        unique case (chip)
            OKS_SLEEP: en_pins = 1'b0;
            OKS_STANDBY: en_pins = !cont;
            OKS_SYNTH: en_pins = !cont;
            OKS_RX: en_pins = 1'b1;
            OKS_TX: en_pins = 1'b1;
            default: en_pins = 1'b0;
        endcase
        s_nxt.irq_oe = en_pins;
        s_nxt.irq_a_out = irq_a_src;
        s_nxt.irq_b_out = (cont && s_r.bs_on) ? s_r.bs_clk : irq_b_src;
        s_nxt.rx_en = rx;
        s_nxt.synth_en = (chip == OKS_SYNTH) || rx || (chip == OKS_TX);
        s_nxt.tx_en = (chip == OKS_TX);
        // Reference output: high-Z in sleep, quiet unless enabled.
        s_nxt.clkout_oe = (chip != OKS_SLEEP) && (chip <= OKS_TX);
        s_nxt.clkout = s_nxt.clkout_oe && clock_output_enable && !s_r.clkout;
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign interrupt_line_a_out = s_r.irq_a_out;
    assign interrupt_line_a_oe = s_r.irq_oe;
    assign interrupt_line_b_out = s_r.irq_b_out;
    assign interrupt_line_b_oe = s_r.irq_oe;
    assign data_out = s_r.data_out;
    assign data_oe = s_r.data_oe;
    assign fifo_bit = s_r.fifo_bit;
    assign fifo_bit_strobe = s_r.fifo_stb;
    assign clkout_out = s_r.clkout;
    assign clkout_oe = s_r.clkout_oe;
    assign rssi_enable = s_r.rx_en;
    assign demod_enable = s_r.rx_en;
    assign rx_digital_enable = s_r.rx_en;
    assign synth_enable = s_r.synth_en;
    assign tx_enable = s_r.tx_en;
    assign bit_sync_active = s_r.bs_on;
    assign slicer_bit = s_r.slice;

    // SPI side runs on the link clock. Deselecting both ports resets it to
    // a constant, so the output lets go even when the clock stands still.
    typedef struct packed {
        logic m;
        logic s;
        logic cfg;
        logic fifo;
        logic oe;
    } oks_spi_t;

    oks_spi_t p_r;
    oks_spi_t p_nxt;
    logic spi_rst_n;

    assign spi_rst_n = arst_n && !(config_port_select_n && fifo_port_select_n);

    // Port choice and output data for the link side.
    always_comb begin
        p_nxt = p_r;
        p_nxt.m = s_r.miso_src;
        p_nxt.s = p_r.m;
        p_nxt.cfg = !config_port_select_n;
        p_nxt.fifo = config_port_select_n && !fifo_port_select_n;
        // The pin enable gets its own flop so the output has no gate behind it.
        p_nxt.oe = !config_port_select_n || !fifo_port_select_n;
    end

    // Link-side register.
    always_ff @(posedge spi_sck or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            p_r <= '0;
        end else begin
            p_r <= p_nxt;
        end
    end

    assign miso_out = p_r.s;
    assign miso_oe = p_r.oe;
    assign spi_config_active = p_r.cfg;
    assign spi_fifo_active = p_r.fifo;

    // Checks on the crystal domain.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence seq_rx_cont;
        (chip == OKS_RX && cont)[*2];
    endsequence

    sequence seq_rx_buf;
        (chip == OKS_RX && !cont)[*2];
    endsequence

    a_fixed_floor: assert property (
        (style == OKS_FIXED)[*2] |-> s_r.thr == $past(ook_floor_level))
        else $error("Fixed threshold differs from floor level.");
    a_slice_cmp: assert property (
        rssi_strobe |=> s_r.slice == ($past(rssi_sample) > $past(s_r.thr)))
        else $error("Slicer output does not match comparison.");
    a_floor_stop: assert property (
        (style == OKS_PEAK && $stable(ook_floor_level))[*2] |-> s_r.thr >= ook_floor_level)
        else $error("Peak threshold fell below floor.");
    a_peak_minus: assert property (
        (style == OKS_PEAK) ##1 (style == OKS_PEAK && $stable(ook_floor_level)
        && $past(s_r.peak) > {1'b0, ook_floor_level} + OKS_PEAK_DROP)
        |-> {1'b0, s_r.thr} == $past(s_r.peak) - OKS_PEAK_DROP)
        else $error("Peak threshold is not peak minus 6 dB.");
    a_sync_bypass: assert property (
        seq_rx_cont ##0 bit_sync_disable && $past(bit_sync_disable) |-> !s_r.bs_on)
        else $error("Bit sync not bypassed by disable bit.");
    a_sync_forced: assert property (
        seq_rx_buf |-> s_r.bs_on)
        else $error("Bit sync not forced on in buffered mode.");
    a_recovered_bit_clock_pin: assert property (
        seq_rx_cont ##1 (s_r.bs_on && $past(s_r.bs_on)) |-> s_r.irq_b_out == $past(s_r.bs_clk))
        else $error("Recovered clock missing on interrupt pin.");
    a_clock_centre: assert property (
        $stable(per)[*2] ##0 $rose(s_r.bs_clk) |-> s_r.ph == half)
        else $error("Recovered clock edge not at bit centre.");
    a_sleep_hiz: assert property (
        (chip == OKS_SLEEP)[*2] |-> !interrupt_line_a_oe && !interrupt_line_b_oe)
        else $error("Interrupt pins driven in sleep.");
    a_rx_enables: assert property (
        ##1 1'b1 |-> rssi_enable == ($past(chip) == OKS_RX))
        else $error("Receive enables outside receive state.");

endmodule

`default_nettype wire
